// ### hdl/mbs_pkg.sv
// Constants and carrier types for the Modbus RTU slave front end.
// Assumes one 25 MHz system clock; all bit timing is counted in it.
package mbs_pkg;
	localparam int unsigned CLK_HZ        = 25_000_000;
	localparam int unsigned DEF_BAUD      = 19200;
	// Bit period in clocks, truncated: 1302 at 19200 baud
	localparam logic [15:0] BIT_DIV_RST   = 16'(CLK_HZ / DEF_BAUD);
	localparam logic [15:0] BIT_DIV_MIN   = 16'h0010;
	localparam logic [15:0] SLAVE_REG_RST = 16'h0001;
	localparam logic [15:0] SLAVE_MAX     = 16'h00f7;
	localparam logic [7:0]  BCAST         = 8'h00;
	// Holding register addresses and limits
	localparam logic [15:0] HR_SPEED      = 16'h0000;
	localparam logic [15:0] HR_SRC        = 16'h0008;
	localparam logic [15:0] HR_BAUD       = 16'h0064;
	localparam logic [15:0] HR_SLAVE      = 16'h0065;
	localparam int          HR_COUNT      = 39;
	localparam logic [15:0] SPEED_MAX     = 16'h2710;
	localparam logic [15:0] SRC_MAX       = 16'h0001;
	localparam logic [15:0] SRC_RST       = 16'h0001;
	// Function and exception codes
	localparam logic [7:0]  FC_RD_HOLD    = 8'h03;
	localparam logic [7:0]  FC_RD_IN      = 8'h04;
	localparam logic [7:0]  FC_WR_ONE     = 8'h06;
	localparam logic [7:0]  FC_EXC        = 8'h80;
	localparam logic [7:0]  EXC_NONE      = 8'h00;
	localparam logic [7:0]  EXC_FUNC      = 8'h01;
	localparam logic [7:0]  EXC_ADDR      = 8'h02;
	localparam logic [7:0]  EXC_VALUE     = 8'h03;
	// Character and frame layout
	localparam int          REQ_LEN       = 8;
	localparam int          CHAR_BITS     = 11;
	localparam int          RX_SAMPLES    = 10;
	// Inter-frame silence: 3.5 characters of 11 bits, rounded up
	localparam logic [5:0]  GAP_BITS      = 6'd39;
	localparam logic [15:0] CRC_INIT      = 16'hffff;
	localparam logic [15:0] CRC_POLY      = 16'ha001;

	typedef struct packed {
		logic [7:0]  slave;
		logic [7:0]  func;
		logic [15:0] addr;
		logic [15:0] arg;
	} mbs_req_t;
endpackage : mbs_pkg

// ### hdl/mbs_crc_byte.sv
// One byte step of the Modbus CRC-16, reflected, combinational.
// Assumes the caller holds the running value in its own register.
`timescale 1ns/100ps
module mbs_crc_byte import mbs_pkg::*; (
	// Running value and new byte
	input  wire logic [15:0] i_crc,
	input  wire logic [7:0]  i_byte,
	// Updated value
	output logic [15:0]      o_crc
);
	always_comb begin
		o_crc = i_crc ^ {8'h00, i_byte};
		for (int i = 0; i < 8; i++) begin
			if (o_crc[0])
				o_crc = (o_crc >> 1) ^ CRC_POLY;
			else
				o_crc = o_crc >> 1;
		end
	end
endmodule : mbs_crc_byte

// ### hdl/mbs_front_end.sv
// Modbus RTU slave front end: character framing, address check, dispatch.
// Assumes serial pins synchronous to i_clk and an external RS-485 driver.
`timescale 1ns/100ps
module mbs_front_end import mbs_pkg::*; #(
	parameter int MAX_QTY = 8
) (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	// Serial link
	input  wire logic        i_rx,
	output logic             o_tx,
	output logic             o_tx_en,
	// Input register space
	output logic [15:0]      o_ir_addr,
	input  wire logic [15:0] i_ir_data,
	// Holding register write strobe
	output logic             o_hr_wr,
	output logic [15:0]      o_hr_waddr,
	output logic [15:0]      o_hr_wdata,
	// Motor control
	output logic             o_ext_enable,
	output logic             o_serial_ctrl,
	output logic [15:0]      o_cmd_speed
);
	typedef enum {RX_IDLE, RX_START, RX_BITS} mbs_rx_st_t;
	typedef enum {M_LISTEN, M_CHECK, M_SEND, M_DRAIN} mbs_m_st_t;

	mbs_rx_st_t  rx_st_q;
	mbs_m_st_t   m_st_q;
	mbs_req_t    req_q;
	mbs_req_t    fr_req;
	logic [15:0] rx_cnt_q, tx_cnt_q, gap_cnt_q, bit_div_q, baud_reg_q, slave_reg_q;
	logic [15:0] rx_crc_q, rx_crc_d, tx_crc_q, tx_crc_d, rd_addr_q, word;
	logic [15:0] hr_q [HR_COUNT];
	logic [7:0]  fr_q [REQ_LEN];
	logic [7:0]  exc_q, exc_d, tx_len_q, tx_len_d, tx_idx_q, tx_byte;
	logic [47:0] echo;
	logic [16:0] rd_end;
	logic [9:0]  rx_sh_q, rx_sh_d;
	logic [10:0] tx_sh_q;
	logic [5:0]  gap_bits_q;
	logic [3:0]  rx_bit_q, tx_bit_q, fr_len_q;
	logic        rx_done_q, rx_err_q, tx_busy_q, tx_en_q, gap_end, frame_ok;
	logic        tx_ld, is_wr, rd_step, qty_ok, hold_ok, val_ok, wr_go;

	function automatic logic [15:0] hr_rd(input logic [15:0] a);
		if (a < 16'(HR_COUNT))
			return hr_q[a[5:0]];
		else if (a == HR_BAUD)
			return baud_reg_q;
		else if (a == HR_SLAVE)
			return slave_reg_q;
		return 16'h0000;
	endfunction : hr_rd

	function automatic logic hr_ok(input logic [15:0] a);
		return (a < 16'(HR_COUNT)) || (a == HR_BAUD) || (a == HR_SLAVE);
	endfunction : hr_ok

	mbs_crc_byte u_rx_crc (.i_crc(rx_crc_q), .i_byte(rx_sh_q[7:0]), .o_crc(rx_crc_d));
	mbs_crc_byte u_tx_crc (.i_crc(tx_crc_q), .i_byte(tx_byte), .o_crc(tx_crc_d));

	assign rx_sh_d = {i_rx, rx_sh_q[9:1]};
	always_ff @(posedge i_clk) begin
		rx_done_q <= 1'b0;
		if (!i_rstn) begin
			rx_st_q  <= RX_IDLE;
			rx_cnt_q <= 16'h0000;
			rx_bit_q <= 4'h0;
			rx_sh_q  <= 10'h000;
			rx_err_q <= 1'b0;
		end else begin
			case (rx_st_q)
				RX_IDLE: begin
					rx_cnt_q <= 16'h0000;
					// Half duplex: own echo is not listened to
					if (!i_rx && !tx_en_q)
						rx_st_q <= RX_START;
				end
				RX_START: begin
					if (rx_cnt_q == {1'b0, bit_div_q[15:1]}) begin
						rx_cnt_q <= 16'h0000;
						rx_bit_q <= 4'h0;
						rx_st_q  <= i_rx ? RX_IDLE : RX_BITS;
					end else
						rx_cnt_q <= rx_cnt_q + 16'h0001;
				end
				RX_BITS: begin
					if (rx_cnt_q == bit_div_q - 16'h0001) begin
						rx_cnt_q <= 16'h0000;
						rx_sh_q  <= rx_sh_d;
						rx_bit_q <= rx_bit_q + 4'h1;
						if (rx_bit_q == 4'(RX_SAMPLES - 1)) begin
							rx_done_q <= 1'b1;
							rx_err_q  <= (^rx_sh_d[8:0]) | !rx_sh_d[9];
							rx_st_q   <= RX_IDLE;
						end
					end else
						rx_cnt_q <= rx_cnt_q + 16'h0001;
				end
				default: rx_st_q <= RX_IDLE;
			endcase
		end
	end

	// frame ends after 3.5 characters of silence
	assign gap_end = (gap_bits_q == GAP_BITS - 6'd1) && (gap_cnt_q == bit_div_q - 16'h0001);
	always_ff @(posedge i_clk) begin
		if (!i_rstn || rx_st_q != RX_IDLE || tx_en_q) begin
			gap_cnt_q  <= 16'h0000;
			gap_bits_q <= 6'd0;
		end else if (gap_bits_q != GAP_BITS) begin
			if (gap_cnt_q == bit_div_q - 16'h0001) begin
				gap_cnt_q  <= 16'h0000;
				gap_bits_q <= gap_bits_q + 6'd1;
			end else
				gap_cnt_q <= gap_cnt_q + 16'h0001;
		end
	end

	// Frame collection; overlong frames are only ever dropped
	always_ff @(posedge i_clk) begin
		if (!i_rstn || gap_end) begin
			fr_len_q <= 4'h0;
			rx_crc_q <= CRC_INIT;
		end else if (rx_done_q && m_st_q == M_LISTEN) begin
			if (fr_len_q < 4'(REQ_LEN))
				fr_q[fr_len_q[2:0]] <= rx_sh_q[7:0];
			if (fr_len_q != 4'hf)
				fr_len_q <= fr_len_q + 4'h1;
			rx_crc_q <= rx_crc_d;
		end
	end

	logic fr_bad_q;
	always_ff @(posedge i_clk) begin
		if (!i_rstn || gap_end)
			fr_bad_q <= 1'b0;
		else if (rx_done_q && m_st_q == M_LISTEN && rx_err_q)
			fr_bad_q <= 1'b1;
	end

	assign fr_req = {fr_q[0], fr_q[1], fr_q[2], fr_q[3], fr_q[4], fr_q[5]};
	// accept only clean frames for us or broadcast
	assign frame_ok = (fr_len_q == 4'(REQ_LEN)) && !fr_bad_q && (rx_crc_q == 16'h0000)
		&& (fr_q[0] == slave_reg_q[7:0] || fr_q[0] == BCAST);

	// Request checks
	assign is_wr   = (req_q.func == FC_WR_ONE);
	assign rd_end  = {1'b0, req_q.addr} + {1'b0, req_q.arg} - 17'h00001;
	assign qty_ok  = (req_q.arg != 16'h0000) && (req_q.arg <= 16'(MAX_QTY));
	assign hold_ok = (rd_end < 17'(HR_COUNT)) || ((req_q.addr == HR_BAUD
		|| req_q.addr == HR_SLAVE) && rd_end <= {1'b0, HR_SLAVE});
	always_comb begin
		val_ok = 1'b1;
		if (req_q.addr == HR_SPEED)
			val_ok = req_q.arg <= SPEED_MAX;
		else if (req_q.addr == HR_SRC)
			val_ok = req_q.arg <= SRC_MAX;
		else if (req_q.addr == HR_BAUD)
			val_ok = req_q.arg >= BIT_DIV_MIN;
		else if (req_q.addr == HR_SLAVE)
			val_ok = (req_q.arg != 16'h0000) && (req_q.arg <= SLAVE_MAX);
	end

	always_comb begin
		case (req_q.func)
			FC_RD_HOLD: exc_d = !qty_ok ? EXC_VALUE : (!hold_ok ? EXC_ADDR : EXC_NONE);
			FC_RD_IN:   exc_d = !qty_ok ? EXC_VALUE : EXC_NONE;
			FC_WR_ONE:  exc_d = !hr_ok(req_q.addr) ? EXC_ADDR : (!val_ok ? EXC_VALUE : EXC_NONE);
			default:    exc_d = EXC_FUNC;
		endcase
		if (exc_d != EXC_NONE)
			tx_len_d = 8'd5;
		else if (is_wr)
			tx_len_d = 8'd8;
		else
			tx_len_d = 8'(16'h0005 + {req_q.arg[14:0], 1'b0});
	end
	assign wr_go = (m_st_q == M_CHECK) && is_wr && (exc_d == EXC_NONE);

	// Response byte generator
	assign echo  = 48'(req_q) << {tx_idx_q[2:0], 3'b000};
	assign word  = (req_q.func == FC_RD_HOLD) ? hr_rd(rd_addr_q) : i_ir_data;
	always_comb begin
		if (tx_idx_q == tx_len_q - 8'd2)
			tx_byte = tx_crc_q[7:0];
		else if (tx_idx_q == tx_len_q - 8'd1)
			tx_byte = tx_crc_q[15:8];
		else if (tx_idx_q == 8'd1 && exc_q != EXC_NONE)
			tx_byte = req_q.func | FC_EXC;
		else if (tx_idx_q == 8'd2 && exc_q != EXC_NONE)
			tx_byte = exc_q;
		else if (tx_idx_q < 8'd2 || is_wr)
			tx_byte = echo[47:40];
		else if (tx_idx_q == 8'd2)
			tx_byte = {req_q.arg[6:0], 1'b0};
		else
			tx_byte = tx_idx_q[0] ? word[15:8] : word[7:0];
	end
	assign tx_ld   = (m_st_q == M_SEND) && !tx_busy_q;
	assign rd_step = tx_ld && !is_wr && exc_q == EXC_NONE && tx_idx_q >= 8'd4
		&& !tx_idx_q[0] && tx_idx_q < tx_len_q - 8'd2;

	// Main sequencer
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			m_st_q    <= M_LISTEN;
			req_q     <= '0;
			exc_q     <= EXC_NONE;
			tx_len_q  <= 8'd0;
			tx_idx_q  <= 8'd0;
			tx_crc_q  <= CRC_INIT;
			rd_addr_q <= 16'h0000;
			tx_en_q   <= 1'b0;
		end else begin
			case (m_st_q)
				M_LISTEN: begin
					if (gap_end && frame_ok) begin
						req_q  <= fr_req;
						m_st_q <= M_CHECK;
					end
				end
				M_CHECK: begin
					exc_q     <= exc_d;
					tx_len_q  <= tx_len_d;
					tx_idx_q  <= 8'd0;
					tx_crc_q  <= CRC_INIT;
					rd_addr_q <= req_q.addr;
					// Broadcasts are acted on but never answered
					if (req_q.slave == BCAST)
						m_st_q <= M_LISTEN;
					else begin
						m_st_q  <= M_SEND;
						tx_en_q <= 1'b1;
					end
				end
				M_SEND: begin
					if (tx_ld) begin
						tx_idx_q <= tx_idx_q + 8'd1;
						if (tx_idx_q < tx_len_q - 8'd2)
							tx_crc_q <= tx_crc_d;
						if (rd_step)
							rd_addr_q <= rd_addr_q + 16'h0001;
						if (tx_idx_q == tx_len_q - 8'd1)
							m_st_q <= M_DRAIN;
					end
				end
				M_DRAIN: begin
					if (!tx_busy_q) begin
						tx_en_q <= 1'b0;
						m_st_q  <= M_LISTEN;
					end
				end
				default: m_st_q <= M_LISTEN;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			tx_sh_q   <= 11'h7ff;
			tx_busy_q <= 1'b0;
			tx_cnt_q  <= 16'h0000;
			tx_bit_q  <= 4'h0;
		end else if (tx_ld) begin
			tx_sh_q   <= {1'b1, ^tx_byte, tx_byte, 1'b0};
			tx_busy_q <= 1'b1;
			tx_cnt_q  <= 16'h0000;
			tx_bit_q  <= 4'h0;
		end else if (tx_busy_q) begin
			if (tx_cnt_q == bit_div_q - 16'h0001) begin
				tx_cnt_q <= 16'h0000;
				tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
				tx_bit_q <= tx_bit_q + 4'h1;
				if (tx_bit_q == 4'(CHAR_BITS - 1))
					tx_busy_q <= 1'b0;
			end else
				tx_cnt_q <= tx_cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			for (int i = 0; i < HR_COUNT; i++)
				hr_q[i] <= (i == int'(HR_SRC)) ? SRC_RST : 16'h0000;
			baud_reg_q  <= BIT_DIV_RST;
			slave_reg_q <= SLAVE_REG_RST;
		end else if (wr_go) begin
			if (req_q.addr < 16'(HR_COUNT))
				hr_q[req_q.addr[5:0]] <= req_q.arg;
			if (req_q.addr == HR_BAUD)
				baud_reg_q <= req_q.arg;
			if (req_q.addr == HR_SLAVE)
				slave_reg_q <= req_q.arg;
		end
	end

	// new rate applies only between frames
	always_ff @(posedge i_clk) begin
		if (!i_rstn)
			bit_div_q <= BIT_DIV_RST;
		else if (m_st_q == M_LISTEN && rx_st_q == RX_IDLE && fr_len_q == 4'h0)
			bit_div_q <= baud_reg_q;
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_hr_wr       <= 1'b0;
			o_hr_waddr    <= 16'h0000;
			o_hr_wdata    <= 16'h0000;
			o_ext_enable  <= 1'b1;
			o_serial_ctrl <= 1'b0;
			o_cmd_speed   <= 16'h0000;
		end else begin
			o_hr_wr       <= wr_go;
			o_hr_waddr    <= wr_go ? req_q.addr : o_hr_waddr;
			o_hr_wdata    <= wr_go ? req_q.arg : o_hr_wdata;
			o_ext_enable  <= hr_q[HR_SRC[5:0]][0];
			o_serial_ctrl <= hr_q[HR_SRC[5:0]] == 16'h0000;
			o_cmd_speed   <= (hr_q[HR_SRC[5:0]] == 16'h0000) ? hr_q[HR_SPEED[5:0]] : 16'h0000;
		end
	end

	assign o_tx      = tx_sh_q[0];
	assign o_tx_en   = tx_en_q;
	assign o_ir_addr = rd_addr_q;

	sequence s_load;
		tx_ld;
	endsequence
	sequence s_char_ok;
		!tx_sh_q[0] && tx_sh_q[10] && !(^tx_sh_q[9:1]);
	endsequence

	tx_char_format_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		s_load |=> s_char_ok) else $error("bad character layout");
	baud_default_a: assert property (@(posedge i_clk)
		$rose(i_rstn) |-> bit_div_q == BIT_DIV_RST) else $error("bad default rate");
	slave_default_a: assert property (@(posedge i_clk)
		$rose(i_rstn) |-> slave_reg_q == SLAVE_REG_RST) else $error("bad default slave");
	drop_bad_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(m_st_q == M_LISTEN && gap_end && !frame_ok) |=> m_st_q == M_LISTEN && !tx_en_q)
		else $error("bad frame answered");
	ir_data_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(tx_ld && req_q.func == FC_RD_IN && exc_q == EXC_NONE && tx_idx_q == 8'd3)
		|-> tx_byte == i_ir_data[15:8]) else $error("input word not sent");
	hr_count_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(tx_ld && req_q.func == FC_RD_HOLD && exc_q == EXC_NONE && tx_idx_q == 8'd2)
		|-> tx_byte == 8'(tx_len_q - 8'd5)) else $error("bad byte count");
	hr_store_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		o_hr_wr |-> hr_rd(o_hr_waddr) == o_hr_wdata) else $error("write not stored");
	rate_follow_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(m_st_q == M_LISTEN && rx_st_q == RX_IDLE && fr_len_q == 4'h0)
		|=> bit_div_q == $past(baud_reg_q)) else $error("rate not taken");
	serial_gate_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		o_cmd_speed != 16'h0000 |-> o_serial_ctrl && !o_ext_enable)
		else $error("speed command while analogue active");
	speed_range_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		hr_q[HR_SPEED[5:0]] <= SPEED_MAX) else $error("speed out of range");
endmodule : mbs_front_end

// ### hdl/_unused_marker_none.sv
`timescale 1ns/100ps

// ### sim/mbs_master_model.sv
// Behavioural Modbus RTU master standing on the far side of the serial link.
// Assumes the bench keeps div equal to the device's current bit period.
`timescale 1ns/100ps
module mbs_master_model #(
	// Poll spacing in clocks, shortened from 100 ms to keep runs short
	parameter int POLL_GAP = 200
) (
	// Clock
	input  wire logic i_clk,
	// Serial link
	input  wire logic i_tx,
	input  wire logic i_tx_en,
	output logic      o_rx
);
	int         div = 1302;
	logic [7:0] rx_q[$];

	// Line biased high while the master is silent
	initial o_rx = 1'b1;

	// start, 8 data LSB first, even parity, one stop
	task automatic send_byte(input logic [7:0] b, input bit bad_par);
		logic [10:0] f;
		f = {1'b1, ^b ^ bad_par, b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			@(negedge i_clk);
			o_rx = f[i];
			repeat (div - 1) @(negedge i_clk);
		end
	endtask : send_byte

	// mid-bit sampling; errs counts framing or driver faults
	task automatic recv_frame(input int wait_max, output int errs);
		logic [10:0] f;
		int          n;
		rx_q = {};
		errs = 0;
		n = wait_max;
		// Falling edge sampling: the line is launched on the rising edge
		while (n > 0) begin
			@(negedge i_clk);
			n--;
			if (i_tx === 1'b0) begin
				repeat (div / 2) @(negedge i_clk);
				for (int i = 0; i < 11; i++) begin
					f[i] = i_tx;
					if (i < 10) repeat (div) @(negedge i_clk);
				end
				if (f[0] !== 1'b0 || f[10] !== 1'b1 || (^f[9:1]) !== 1'b0 || i_tx_en !== 1'b1)
					errs++;
				rx_q.push_back(f[8:1]);
				n = 2 * div;
			end
		end
	endtask : recv_frame

	task automatic poll_gap;
		repeat (POLL_GAP) @(negedge i_clk);
	endtask : poll_gap
endmodule : mbs_master_model

// ### sim/mbs_front_end_tb.sv
// Self-checking bench for the Modbus RTU slave front end.
// Assumes a 25 MHz clock; the bench sets the link rate the master model uses.
`timescale 1ns/100ps
module mbs_front_end_tb import mbs_pkg::*; ;
	typedef struct {
		mbs_req_t   req;
		int         fault;
		int         kind;
		logic [7:0] code;
	} mbs_row_t;

	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        rx;
	logic        tx;
	logic        tx_en;
	logic [15:0] ir_addr;
	logic [15:0] ir_data;
	logic        hr_wr;
	logic [15:0] hr_waddr;
	logic [15:0] hr_wdata;
	logic        ext_en;
	logic        ser_ctrl;
	logic [15:0] cmd_speed;
	logic [15:0] hr[0:127];
	int          fails = 0;
	int          checks = 0;
	int          wr_cnt = 0;
	mbs_row_t    rows[16];

	always #20 clk = ~clk;
	// Input register contents derived from the address being read
	assign ir_data = ir_addr ^ 16'h5a5a;
	// Strobe counted where it is settled, not on its launching edge
	always @(negedge clk) if (hr_wr === 1'b1) wr_cnt++;

	mbs_front_end #(.MAX_QTY(8)) dut_u (
		.i_clk(clk), .i_rstn(rstn), .i_rx(rx), .o_tx(tx), .o_tx_en(tx_en),
		.o_ir_addr(ir_addr), .i_ir_data(ir_data), .o_hr_wr(hr_wr),
		.o_hr_waddr(hr_waddr), .o_hr_wdata(hr_wdata), .o_ext_enable(ext_en),
		.o_serial_ctrl(ser_ctrl), .o_cmd_speed(cmd_speed)
	);

	mbs_master_model #(.POLL_GAP(200)) mm_u (
		.i_clk(clk), .i_tx(tx), .i_tx_en(tx_en), .o_rx(rx)
	);

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic results;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : results

	function automatic logic [15:0] crc16(input logic [7:0] q[$]);
		logic [15:0] c;
		c = CRC_INIT;
		foreach (q[i]) begin
			c ^= {8'h00, q[i]};
			for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction : crc16

	task automatic check_idle;
		check("tx idle", 32'(tx), 32'h1);
		check("driver off", 32'(tx_en), 32'h0);
		check("motor outputs", 32'({ext_en, ser_ctrl, cmd_speed}), 32'h0002_0000);
		check("write strobe", 32'(hr_wr), 32'h0);
		check("write address data", {hr_waddr, hr_wdata}, 32'h0);
		check("input address", 32'(ir_addr), 32'h0);
	endtask : check_idle

	task automatic run_row(input mbs_row_t r);
		logic [7:0]  q[$];
		logic [7:0]  e[$];
		logic [15:0] c;
		logic [15:0] w;
		int          errs;
		int          w0;
		bit          wr;
		q = {r.req.slave, r.req.func, r.req.addr[15:8], r.req.addr[7:0],
			r.req.arg[15:8], r.req.arg[7:0]};
		e = {r.req.slave, r.req.func};
		case (r.kind)
			1: e = q;
			2, 3: begin
				e.push_back(8'(2 * r.req.arg));
				for (int i = 0; i < int'(r.req.arg); i++) begin
					w = (r.kind == 2) ? hr[r.req.addr + i] : (r.req.addr + 16'(i)) ^ 16'h5a5a;
					e.push_back(w[15:8]);
					e.push_back(w[7:0]);
				end
			end
			4: begin
				e[1] = r.req.func | FC_EXC;
				e.push_back(r.code);
			end
			default: e = {};
		endcase
		if (e.size() > 0) begin
			c = crc16(e);
			e.push_back(c[7:0]);
			e.push_back(c[15:8]);
		end
		c = crc16(q) ^ ((r.fault == 1) ? 16'h0001 : 16'h0000);
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		w0 = wr_cnt;
		foreach (q[i]) mm_u.send_byte(q[i], r.fault == 2 && i == 2);
		mm_u.recv_frame(45 * mm_u.div, errs);
		check("reply framing", 32'(errs), 32'h0);
		check("reply length", 32'(mm_u.rx_q.size()), 32'(e.size()));
		foreach (e[i]) if (i < mm_u.rx_q.size()) check("reply byte", 32'(mm_u.rx_q[i]), 32'(e[i]));
		check("driver released", 32'(tx_en), 32'h0);
		wr = r.req.func == FC_WR_ONE && r.fault == 0 && (r.kind == 1 || r.req.slave == BCAST);
		check("write count", 32'(wr_cnt - w0), 32'(wr));
		if (wr) begin
			hr[r.req.addr] = r.req.arg;
			check("write port", {hr_waddr, hr_wdata}, {r.req.addr, r.req.arg});
			if (r.req.addr == HR_BAUD) mm_u.div = int'(r.req.arg);
		end
		check("external enable", 32'(ext_en), 32'(hr[8][0]));
		check("serial control", 32'(ser_ctrl), 32'(hr[8] == 16'h0));
		check("speed command", 32'(cmd_speed), 32'((hr[8] == 16'h0) ? hr[0] : 16'h0));
		mm_u.poll_gap();
	endtask : run_row

	initial begin
		foreach (hr[i]) hr[i] = 16'h0000;
		hr[8] = 16'h0001;
		hr[100] = 16'h0516;
		hr[101] = 16'h0001;
		// First row runs at the reset rate; later rows at 16 clocks a bit
		rows = '{
			'{'{BCAST, FC_WR_ONE, HR_BAUD, 16'h0010}, 0, 0, 8'h00},
			'{'{8'h01, FC_WR_ONE, HR_SPEED, SPEED_MAX}, 0, 1, 8'h00},
			'{'{8'h01, FC_RD_HOLD, HR_SPEED, 16'h0001}, 0, 2, 8'h00},
			'{'{8'h01, FC_RD_IN, 16'h0005, 16'h0003}, 0, 3, 8'h00},
			'{'{8'h01, FC_WR_ONE, HR_SRC, 16'h0000}, 0, 1, 8'h00},
			'{'{8'h01, FC_RD_HOLD, HR_BAUD, 16'h0002}, 0, 2, 8'h00},
			'{'{8'h01, 8'h07, HR_SPEED, 16'h0001}, 0, 4, EXC_FUNC},
			'{'{8'h01, FC_RD_HOLD, 16'h0032, 16'h0001}, 0, 4, EXC_ADDR},
			'{'{8'h01, FC_WR_ONE, HR_SPEED, 16'h2711}, 0, 4, EXC_VALUE},
			'{'{8'h02, FC_RD_HOLD, HR_SPEED, 16'h0001}, 0, 0, 8'h00},
			'{'{8'h01, FC_RD_HOLD, HR_SPEED, 16'h0001}, 1, 0, 8'h00},
			'{'{8'h01, FC_RD_HOLD, HR_SPEED, 16'h0001}, 2, 0, 8'h00},
			'{'{8'h01, FC_WR_ONE, HR_SLAVE, 16'h0005}, 0, 1, 8'h00},
			'{'{8'h01, FC_RD_HOLD, HR_SLAVE, 16'h0001}, 0, 0, 8'h00},
			'{'{8'h05, FC_RD_IN, 16'h0000, 16'h0008}, 0, 3, 8'h00},
			'{'{8'h05, FC_RD_IN, 16'h0000, 16'h0009}, 0, 4, EXC_VALUE}
		};
		repeat (12) @(negedge clk);
		rstn = 1'b1;
		@(negedge clk);
		check_idle();
		foreach (rows[i]) run_row(rows[i]);
		// Second reset after traffic: outputs return to their idle values
		@(negedge clk);
		rstn = 1'b0;
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		@(negedge clk);
		check_idle();
		results();
	end
endmodule : mbs_front_end_tb
